//--- aocp_core.v
// Numerically controlled oscillator: clock select, phase accumulator and output shaping.
//
// Strobed register access was left to the implementer.
`include "aocp_regs.vh"
`default_nettype none

module aocp_core (
   // Clock and reset.
   input  wire                      clock_in,
   input  wire                      reset_n_in,
   // Register port.
   input  wire [`AOCP_ADDR_W-1:0]   addr_in,
   input  wire [7:0]                wdata_in,
   input  wire                      write_in,
   input  wire                      read_in,
   output reg  [7:0]                rdata_out,
   // Candidate input clocks, sampled on clock_in.
   input  wire                      system_osc_clock_in,
   input  wire                      high_freq_internal_osc_in,
   input  wire                      low_freq_internal_osc_in,
   input  wire                      medium_freq_internal_osc_500k_in,
   input  wire                      medium_freq_internal_osc_32k_in,
   input  wire                      secondary_osc_in,
   input  wire                      reference_clock_out_in,
   input  wire                      logic_cell_one_output_in,
   input  wire                      logic_cell_two_output_in,
   input  wire                      logic_cell_three_output_in,
   input  wire                      logic_cell_four_output_in,
   // Oscillator output.
   output reg                       osc_out
);

   // Software state.
   reg                     enable;
   reg                     output_invert;
   reg                     pulse_freq_mode_sel;
   reg [2:0]               pulse_width_sel;
   reg [3:0]               clock_source_sel;
   reg [`AOCP_INC_W-1:0]   phase_increment;
   reg [`AOCP_INC_W-1:0]   increment_working_copy;
   reg                     load_pending;
   // Datapath state.
   reg [`AOCP_ACC_W-1:0]   phase_accumulator;
   reg                     selected_clock_prev;
   reg                     raw_out;
   reg [7:0]               pulse_count;
   // Combinational signals.
   reg                     selected_clock;
   reg [7:0]               width_periods;
   reg [7:0]               next_rdata;
   wire                    clock_rise;
   wire                    clock_fall;
   wire [`AOCP_ACC_W:0]    sum;
   wire                    overflow;
   wire                    acc_write;

   // Source multiplexer; reserved codes select no clock so the accumulator stays put.
   always @* begin
      case (clock_source_sel)
         `AOCP_SRC_SYSTEM_OSC:   selected_clock = system_osc_clock_in;
         `AOCP_SRC_HIGH_FREQ:    selected_clock = high_freq_internal_osc_in;
         `AOCP_SRC_LOW_FREQ:     selected_clock = low_freq_internal_osc_in;
         `AOCP_SRC_MEDIUM_500K:  selected_clock = medium_freq_internal_osc_500k_in;
         `AOCP_SRC_MEDIUM_32K:   selected_clock = medium_freq_internal_osc_32k_in;
         `AOCP_SRC_SECONDARY:    selected_clock = secondary_osc_in;
         `AOCP_SRC_REFERENCE:    selected_clock = reference_clock_out_in;
         `AOCP_SRC_CELL_ONE:     selected_clock = logic_cell_one_output_in;
         `AOCP_SRC_CELL_TWO:     selected_clock = logic_cell_two_output_in;
         `AOCP_SRC_CELL_THREE:   selected_clock = logic_cell_three_output_in;
         `AOCP_SRC_CELL_FOUR:    selected_clock = logic_cell_four_output_in;
         default:                selected_clock = 1'b0;
      endcase
   end

   // Edges of the selected clock; the sources are synchronous, so one stage suffices.
   assign clock_rise = selected_clock & ~selected_clock_prev;
   assign clock_fall = ~selected_clock & selected_clock_prev;

   // Sum with carry; the carry out of the top bit is the overflow event.
   assign sum      = {1'b0, phase_accumulator} + {1'b0, increment_working_copy};
   assign overflow = enable & clock_rise & sum[`AOCP_ACC_W];
   assign acc_write = write_in & ((addr_in == `AOCP_OFF_ACC_LOW) | (addr_in == `AOCP_OFF_ACC_HIGH) |
                                  (addr_in == `AOCP_OFF_ACC_UPPER));

   // Pulse length in input clock periods, minus one, doubling per code step.
   always @* begin
      case (pulse_width_sel)
         3'h0:    width_periods = 8'h00;
         3'h1:    width_periods = 8'h01;
         3'h2:    width_periods = 8'h03;
         3'h3:    width_periods = 8'h07;
         3'h4:    width_periods = 8'h0F;
         3'h5:    width_periods = 8'h1F;
         3'h6:    width_periods = 8'h3F;
         default: width_periods = 8'h7F;
      endcase
   end

   // Edge history of the selected clock.
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         selected_clock_prev <= 1'b0;
      end else begin
         selected_clock_prev <= selected_clock;
      end
   end

   // Control registers and the increment buffer.
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         enable              <= 1'b0;
         output_invert       <= 1'b0;
         pulse_freq_mode_sel <= 1'b0;
         pulse_width_sel     <= `AOCP_RESET_WIDTH;
         clock_source_sel    <= `AOCP_RESET_SRC;
         phase_increment     <= `AOCP_RESET_INC;
      end else if (write_in) begin
         case (addr_in)
            `AOCP_OFF_INC_LOW:   phase_increment[7:0]   <= wdata_in;
            `AOCP_OFF_INC_HIGH:  phase_increment[15:8]  <= wdata_in;
            `AOCP_OFF_INC_UPPER: phase_increment[19:16] <= wdata_in[3:0];
            `AOCP_OFF_CONTROL: begin
               enable              <= wdata_in[`AOCP_CON_ENABLE_BIT];
               output_invert       <= wdata_in[`AOCP_CON_INVERT_BIT];
               pulse_freq_mode_sel <= wdata_in[`AOCP_CON_MODE_BIT];
            end
            `AOCP_OFF_CLOCK_CONTROL: begin
               pulse_width_sel  <= wdata_in[`AOCP_CLK_WIDTH_HI:`AOCP_CLK_WIDTH_LO];
               clock_source_sel <= wdata_in[`AOCP_CLK_SRC_HI:`AOCP_CLK_SRC_LO];
            end
            default: begin
            end
         endcase
      end
   end

   // Working copy: a low-byte write arms a load taken at the next falling input clock edge.
   // The copy moves while disabled too, so a new rate is in place before enabling.
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         load_pending           <= 1'b0;
         increment_working_copy <= `AOCP_RESET_INC;
      end else begin
         if (load_pending && clock_fall) begin
            increment_working_copy <= phase_increment;
         end
         if (write_in && (addr_in == `AOCP_OFF_INC_LOW)) begin
            load_pending <= 1'b1;
         end else if (clock_fall) begin
            load_pending <= 1'b0;
         end
      end
   end

   // Accumulator; software writes win over an add in the same cycle but are undefined while running.
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         phase_accumulator <= `AOCP_RESET_ACC;
      end else if (acc_write) begin
         case (addr_in)
            `AOCP_OFF_ACC_LOW:  phase_accumulator[7:0]   <= wdata_in;
            `AOCP_OFF_ACC_HIGH: phase_accumulator[15:8]  <= wdata_in;
            default:            phase_accumulator[19:16] <= wdata_in[3:0];
         endcase
      end else if (enable && clock_rise) begin
         phase_accumulator <= sum[`AOCP_ACC_W-1:0];
      end
   end

   // Output shaping; disabling clears the waveform so it restarts low.
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         raw_out     <= 1'b0;
         pulse_count <= 8'h00;
      end else if (!enable) begin
         raw_out     <= 1'b0;
         pulse_count <= 8'h00;
      end else if (!pulse_freq_mode_sel) begin
         pulse_count <= 8'h00;
         if (overflow) begin
            raw_out <= ~raw_out;
         end
      end else if (overflow) begin
         raw_out     <= 1'b1;
         pulse_count <= width_periods;
      end else if (clock_rise && raw_out) begin
         if (pulse_count == 8'h00) begin
            raw_out <= 1'b0;
         end else begin
            pulse_count <= pulse_count - 8'h01;
         end
      end
   end

   // Output pin after polarity; held at the inverted idle level while disabled.
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         osc_out <= 1'b0;
      end else begin
         osc_out <= raw_out ^ output_invert;
      end
   end

   // Read multiplexer; unused bits and unmapped addresses read zero.
   always @* begin
      next_rdata = `AOCP_RESET_BYTE;
      case (addr_in)
         `AOCP_OFF_ACC_LOW:   next_rdata = phase_accumulator[7:0];
         `AOCP_OFF_ACC_HIGH:  next_rdata = phase_accumulator[15:8];
         `AOCP_OFF_ACC_UPPER: next_rdata = {4'h0, phase_accumulator[19:16]};
         `AOCP_OFF_INC_LOW:   next_rdata = phase_increment[7:0];
         `AOCP_OFF_INC_HIGH:  next_rdata = phase_increment[15:8];
         `AOCP_OFF_INC_UPPER: next_rdata = {4'h0, phase_increment[19:16]};
         `AOCP_OFF_CONTROL: begin
            next_rdata[`AOCP_CON_ENABLE_BIT] = enable;
            next_rdata[`AOCP_CON_OUT_BIT]    = osc_out;
            next_rdata[`AOCP_CON_INVERT_BIT] = output_invert;
            next_rdata[`AOCP_CON_MODE_BIT]   = pulse_freq_mode_sel;
         end
         `AOCP_OFF_CLOCK_CONTROL: next_rdata = {pulse_width_sel, 1'b0, clock_source_sel};
         default: next_rdata = `AOCP_RESET_BYTE;
      endcase
   end

   // Read data stand for exactly the cycle after the strobe.
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_out <= `AOCP_RESET_BYTE;
      end else if (read_in) begin
         rdata_out <= next_rdata;
      end else begin
         rdata_out <= `AOCP_RESET_BYTE;
      end
   end

endmodule // aocp_core

`default_nettype wire

//--- aocp_regs.vh
// Register offsets, field positions, reset values and widths of the oscillator block.
`ifndef AOCP_REGS_VH
`define AOCP_REGS_VH
`define AOCP_ADDR_W 12
`define AOCP_OFF_ACC_LOW 12'h58C
`define AOCP_OFF_ACC_HIGH 12'h58D
`define AOCP_OFF_ACC_UPPER 12'h58E
`define AOCP_OFF_INC_LOW 12'h58F
`define AOCP_OFF_INC_HIGH 12'h590
`define AOCP_OFF_INC_UPPER 12'h591
`define AOCP_OFF_CONTROL 12'h592
`define AOCP_OFF_CLOCK_CONTROL 12'h593
`define AOCP_CON_ENABLE_BIT 7
`define AOCP_CON_OUT_BIT 5
`define AOCP_CON_INVERT_BIT 4
`define AOCP_CON_MODE_BIT 0
`define AOCP_CLK_WIDTH_HI 7
`define AOCP_CLK_WIDTH_LO 5
`define AOCP_CLK_SRC_HI 3
`define AOCP_CLK_SRC_LO 0
`define AOCP_ACC_W 20
`define AOCP_INC_W 20
`define AOCP_RESET_BYTE 8'h00
`define AOCP_RESET_INC 20'h00000
`define AOCP_RESET_ACC 20'h00000
`define AOCP_RESET_SRC 4'h0
`define AOCP_RESET_WIDTH 3'h0
`define AOCP_SRC_SYSTEM_OSC 4'h0
`define AOCP_SRC_HIGH_FREQ 4'h1
`define AOCP_SRC_LOW_FREQ 4'h2
`define AOCP_SRC_MEDIUM_500K 4'h3
`define AOCP_SRC_MEDIUM_32K 4'h4
`define AOCP_SRC_SECONDARY 4'h5
`define AOCP_SRC_REFERENCE 4'h6
`define AOCP_SRC_CELL_ONE 4'h7
`define AOCP_SRC_CELL_TWO 4'h8
`define AOCP_SRC_CELL_THREE 4'h9
`define AOCP_SRC_CELL_FOUR 4'hA
`define AOCP_FDC_DIVIDE 2
`endif

//--- aocp_checker.sv
// Concurrent checks on the register port and output of the oscillator block.
`default_nettype none
module aocp_checker (
   // Watched ports.
   input wire logic        clock_in,
   input wire logic        reset_n_in,
   input wire logic [11:0] addr_in,
   input wire logic [7:0]  wdata_in,
   input wire logic        write_in,
   input wire logic        read_in,
   input wire logic [7:0]  rdata_out,
   input wire logic        osc_out
);
   logic [7:0] ctl;
   logic [7:0] clk;
   logic [1:0] quiet;
   // Shadow registers; quiet counts idle cycles so settled output can be judged.
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ctl   <= 8'h00;
         clk   <= 8'h00;
         quiet <= 2'h0;
      end else begin
         if (write_in && addr_in == 12'h592) ctl <= wdata_in;
         if (write_in && addr_in == 12'h593) clk <= wdata_in;
         quiet <= write_in ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
      end
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   a_rdata_idle_zero: assert property (!read_in |=> rdata_out == 8'h00)
      else $error("read data not zero outside a read");
   a_clock_ctl_read: assert property (read_in && addr_in == 12'h593 |=> rdata_out == $past(clk & 8'hEF))
      else $error("clock control readback wrong");
   a_control_read: assert property (read_in && addr_in == 12'h592 |=> (rdata_out & 8'hDF) == $past(ctl & 8'h91))
      else $error("control readback wrong");
   a_out_bit_read: assert property (read_in && addr_in == 12'h592 |=> rdata_out[5] == $past(osc_out))
      else $error("output bit does not follow output");
   a_upper_nibble: assert property (read_in && addr_in inside {12'h591, 12'h58E} |=> rdata_out[7:4] == 4'h0)
      else $error("upper nibble not zero");
   a_unmapped_zero: assert property (read_in && (addr_in < 12'h58C || addr_in > 12'h593) |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_disabled_level: assert property (quiet == 2'h3 && !ctl[7] |-> osc_out == ctl[4])
      else $error("disabled output not at invert level");
   a_reserved_still: assert property (quiet == 2'h3 && clk[3:0] > 4'hA |=> $stable(osc_out))
      else $error("output moved on reserved source");
endmodule // aocp_checker
bind aocp_core aocp_checker chk_i (.clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out), .osc_out(osc_out));
`default_nettype wire

//--- accum_oscillator_clock_pulse_tb_top.sv
// Self-checking testbench of the oscillator block.
`default_nettype none
module accum_oscillator_clock_pulse_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock_in = 1'b0;
   logic        reset_n_in = 1'b0;
   logic [11:0] addr_in = 12'h000;
   logic [7:0]  wdata_in = 8'h00;
   logic        write_in = 1'b0;
   logic        read_in = 1'b0;
   logic [7:0]  rdata_out;
   logic        osc_out;
   logic [10:0] src_en = 11'h000;
   logic        tog = 1'b0;
   logic        prev;
   wire  [10:0] src = src_en & {11{tog}};
   int          n_errors = 0;
   int          compares = 0;
   aocp_core dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
      .system_osc_clock_in(src[0]), .high_freq_internal_osc_in(src[1]), .low_freq_internal_osc_in(src[2]),
      .medium_freq_internal_osc_500k_in(src[3]), .medium_freq_internal_osc_32k_in(src[4]),
      .secondary_osc_in(src[5]), .reference_clock_out_in(src[6]), .logic_cell_one_output_in(src[7]),
      .logic_cell_two_output_in(src[8]), .logic_cell_three_output_in(src[9]),
      .logic_cell_four_output_in(src[10]), .osc_out(osc_out));
   // Clock and a source pattern rising every second cycle.
   initial forever #4 clock_in = ~clock_in;
   always @(posedge clock_in) tog <= ~tog;
   task automatic end_of_test();
      $display("n_errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= d;
      write_in <= 1'b1;
      @(posedge clock_in);
      write_in <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clock_in);
      addr_in <= a;
      read_in <= 1'b1;
      @(posedge clock_in);
      read_in <= 1'b0;
      #1 check({8'h00, rdata_out}, {8'h00, exp});
   endtask
   // Low byte goes last because its write arms the working copy load.
   task automatic set_inc(input logic [19:0] v);
      wr(12'h591, {4'h0, v[19:16]});
      wr(12'h590, v[15:8]);
      wr(12'h58F, v[7:0]);
   endtask
   // Bounded wait so a stuck output ends the run instead of hanging it.
   task automatic wait_osc(input logic lvl);
      int n;
      n = 0;
      while (osc_out !== lvl) begin
         @(posedge clock_in);
         #1 n++;
         if (n > 2000) begin
            n_errors++;
            end_of_test();
         end
      end
   endtask
   task automatic high_len(input logic [15:0] exp);
      int n;
      wait_osc(1'b0);
      wait_osc(1'b1);
      n = 0;
      while (osc_out === 1'b1 && n < 2000) begin
         @(posedge clock_in);
         #1 n++;
      end
      check(n[15:0], exp);
   endtask
   // Reset values, field layout, reserved bit and an unmapped address.
   task automatic t_regs();
      rd(12'h593, 8'h00);
      rd(12'h592, 8'h00);
      wr(12'h593, 8'hFF);
      rd(12'h593, 8'hEF);
      rd(12'h594, 8'h00);
   endtask
   // Overflow every 256 source rises; each rise is two clock cycles.
   task automatic t_pulse();
      wr(12'h593, 8'h00);
      src_en <= 11'h001;
      set_inc(20'h01000);
      wr(12'h592, 8'h81);
      for (int p = 0; p < 8; p++) begin
         wr(12'h593, {p[2:0], 5'h00});
         high_len(16'h0002 << p);
      end
      wr(12'h592, 8'h80);
      high_len(16'h0200);
   endtask
   // Each code follows only its own input; reserved codes follow none.
   task automatic t_sources();
      int moves;
      set_inc(20'h80000);
      rd(12'h591, 8'h08);
      for (int c = 0; c < 16; c++) begin
         wr(12'h593, {4'h0, c[3:0]});
         for (int k = 0; k < 2; k++) begin
            @(posedge clock_in);
            src_en <= k ? (11'h001 << c) : ~(11'h001 << c);
            repeat (6) @(posedge clock_in);
            #1 prev = osc_out;
            moves = 0;
            repeat (32) begin
               @(posedge clock_in);
               #1 if (osc_out !== prev) moves++;
               prev = osc_out;
            end
            check({15'h0000, moves != 0}, {15'h0000, k == 1 && c < 11});
         end
      end
   endtask
   // A disabled block rests at the invert level.
   task automatic t_disable();
      wr(12'h592, 8'h10);
      repeat (3) @(posedge clock_in);
      #1 check({15'h0000, osc_out}, 16'h0001);
      rd(12'h592, 8'h30);
      wr(12'h592, 8'h00);
      repeat (3) @(posedge clock_in);
      #1 check({15'h0000, osc_out}, 16'h0000);
   endtask
   // Upper and high bytes alone must not reach the adder; the low byte commits all three.
   task automatic t_buffer();
      wr(12'h593, 8'h00);
      src_en <= 11'h001;
      wr(12'h591, 8'h00);
      wr(12'h590, 8'h10);
      high_len(16'h0004);
      wr(12'h58F, 8'h00);
      repeat (4) @(posedge clock_in);
      high_len(16'h0200);
   endtask
   // A reset in mid-run returns every field and the output to zero.
   task automatic t_reset();
      wr(12'h593, 8'hA5);
      wr(12'h58F, 8'h3C);
      reset_n_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      reset_n_in <= 1'b1;
      #1 check({15'h0000, osc_out}, 16'h0000);
      rd(12'h593, 8'h00);
      rd(12'h58F, 8'h00);
      rd(12'h58C, 8'h00);
      rd(12'h592, 8'h00);
   endtask
   // Main sequence after three cycles of reset.
   initial begin
      repeat (3) @(posedge clock_in);
      reset_n_in <= 1'b1;
      t_regs();
      t_pulse();
      t_sources();
      t_buffer();
      t_reset();
      t_disable();
      end_of_test();
   end
endmodule // accum_oscillator_clock_pulse_tb_top
`default_nettype wire
